// ===== rtl/tcsi_top.v
// Teach capture, stop reactions and start interlocks of the drive.
`timescale 1ns/1ps
`include "tcsi_defs.vh"

module tcsi_top #(
	parameter POS_W       = 32,
	parameter IDX_W       = 5,
	parameter TABLE_DEPTH = 32,
	parameter SPD_W       = 20,
	parameter GEAR_W      = 24,
	parameter HOLD_CYCLES = `TCSI_HOLD_CYCLES
) (
	// Clock and reset
	input  wire              i_clk,
	input  wire              i_nrst,
	// Controller inputs
	input  wire              i_servo_on_input,
	input  wire              i_forced_stop_two,
	input  wire              i_fwd_stroke_limit,
	input  wire              i_rev_stroke_limit,
	input  wire              i_fwd_start_input,
	input  wire              i_rev_start_input,
	input  wire              i_operation_mode_select,
	input  wire              i_teach_input,
	// Front panel buttons
	input  wire              i_btn_set,
	input  wire              i_btn_mode,
	input  wire              i_btn_up,
	input  wire              i_btn_down,
	// Drive status and configuration
	input  wire              i_point_table_mode,
	input  wire              i_test_mode,
	input  wire              i_test_forced_stop,
	input  wire [3:0]        i_position_command_config,
	input  wire              i_home_return_done,
	input  wire              i_travel_complete,
	input  wire              i_cmd_output_zero,
	input  wire [POS_W-1:0]  i_cmd_position,
	input  wire              i_alarm,
	input  wire              i_alarm_dbrake_class,
	input  wire [SPD_W-1:0]  i_speed_abs,
	input  wire [GEAR_W-1:0] i_gear_numerator,
	// Table read port
	input  wire [IDX_W-1:0]  i_table_rd_idx,
	output reg  [POS_W-1:0]  o_table_rd_data,
	// Drive outputs
	output reg               o_drive_ready,
	output reg               o_power_stage_on,
	output reg  [2:0]        o_stop_action,
	output reg               o_run_fwd,
	output reg               o_run_rev,
	output reg               o_forced_stop_warning,
	output reg               o_abs_counter_speed_warning,
	// Display
	output reg  [2:0]        o_disp_state,
	output reg  [IDX_W-1:0]  o_disp_table_idx,
	output reg               o_blink_lower,
	output reg               o_blink_upper,
	output reg               o_teach_written
);

	// ==========================================================
	// Helpers
	// Rising-edge test shared by the panel buttons and the teach input.
	function edge_rise;
		input cur;
		input prev;
		begin
			edge_rise = cur & ~prev;
		end
	endfunction

	// ==========================================================
	// Button and input edge detection
	// The delay flops reset low, the idle level of every input, so no false
	// edge follows reset.
	reg set_d;
	reg mode_d;
	reg up_d;
	reg down_d;
	reg teach_d;
	reg tfs_d;

	wire set_rise;
	wire set_fall;
	wire mode_rise;
	wire up_rise;
	wire down_rise;
	wire teach_rise;
	wire tfs_rise;

	assign set_rise   = edge_rise(i_btn_set, set_d);
	assign set_fall   = edge_rise(set_d, i_btn_set);
	assign mode_rise  = edge_rise(i_btn_mode, mode_d);
	assign up_rise    = edge_rise(i_btn_up, up_d);
	assign down_rise  = edge_rise(i_btn_down, down_d);
	assign teach_rise = edge_rise(i_teach_input, teach_d);
	assign tfs_rise   = edge_rise(i_test_forced_stop, tfs_d);

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			set_d   <= 1'b0;
			mode_d  <= 1'b0;
			up_d    <= 1'b0;
			down_d  <= 1'b0;
			teach_d <= 1'b0;
			tfs_d   <= 1'b0;
		end else begin
			set_d   <= i_btn_set;
			mode_d  <= i_btn_mode;
			up_d    <= i_btn_up;
			down_d  <= i_btn_down;
			teach_d <= i_teach_input;
			tfs_d   <= i_test_forced_stop;
		end
	end

	// ==========================================================
	// Shared timer for startup and long set press
	// One counter serves both because they never overlap in time.
	// It stops at its end count, so a long hold cannot wrap and fire twice.
	reg  [31:0] timer;
	wire        timer_done;
	wire        timing_startup;
	wire        timing_hold;

	assign timing_startup = (o_disp_state == `TCSI_DISP_STARTUP);
	assign timing_hold    = (o_disp_state == `TCSI_DISP_TEACH_INIT)
			&& i_btn_set && set_d;
	assign timer_done     = (timer >= HOLD_CYCLES - 1);

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			timer <= 32'h0;
		end else if ((timing_startup || timing_hold) && !timer_done) begin
			timer <= timer + 32'h1;
		end else if (!(timing_startup || timing_hold)) begin
			timer <= 32'h0;
		end
	end

	// ==========================================================
	// Teach conditions
	wire teach_allowed;
	wire teach_request;
	wire set_consumed;

	assign teach_allowed = i_point_table_mode
			&& (i_position_command_config == `TCSI_CMD_ABSOLUTE)
			&& i_home_return_done
			&& i_cmd_output_zero && i_travel_complete;
	// Set writes only in state 4; elsewhere it only steers the display.
	assign teach_request = teach_rise
			|| (set_rise && o_disp_state == `TCSI_DISP_TEACH_RDY);

	// A long press also ends with a release; that release must not teach.
	reg hold_fired;
	assign set_consumed = hold_fired;

	// ==========================================================
	// Display state machine
	// Last table entry; up and down wrap at the ends of the table.
	localparam [31:0] LAST_IDX = TABLE_DEPTH - 1;
	reg [2:0]       next_disp;
	reg [IDX_W-1:0] next_idx;

	always @* begin
		next_disp = o_disp_state;
		next_idx  = o_disp_table_idx;
		case (o_disp_state)
		`TCSI_DISP_STARTUP: begin
			if (timer_done) begin
				next_disp = `TCSI_DISP_LIVE;
			end
		end
		`TCSI_DISP_LIVE: begin
			if (i_point_table_mode && mode_rise) begin
				next_disp = `TCSI_DISP_TEACH_INIT;
			end
		end
		`TCSI_DISP_TEACH_INIT: begin
			if (!i_point_table_mode) begin
				next_disp = `TCSI_DISP_LIVE;
			end else if (timing_hold && timer_done) begin
				next_disp = `TCSI_DISP_SEL_TABLE;
			end else if (mode_rise) begin
				next_disp = `TCSI_DISP_LIVE;
			end
		end
		`TCSI_DISP_SEL_TABLE: begin
			if (mode_rise) begin
				next_disp = `TCSI_DISP_TEACH_INIT;
			end else if (set_rise && !set_consumed) begin
				next_disp = `TCSI_DISP_TEACH_RDY;
			end else if (up_rise) begin
				next_idx = (o_disp_table_idx == LAST_IDX[IDX_W-1:0]) ?
						{IDX_W{1'b0}} :
						o_disp_table_idx + 1'b1;
			end else if (down_rise) begin
				next_idx = (o_disp_table_idx == {IDX_W{1'b0}}) ?
						LAST_IDX[IDX_W-1:0] :
						o_disp_table_idx - 1'b1;
			end
		end
		`TCSI_DISP_TEACH_RDY: begin
			if (mode_rise) begin
				next_disp = `TCSI_DISP_TEACH_INIT;
			end
		end
		default: begin
			next_disp = `TCSI_DISP_LIVE;
		end
		endcase
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_disp_state     <= `TCSI_DISP_STARTUP;
			o_disp_table_idx <= {IDX_W{1'b0}};
			o_blink_lower    <= 1'b0;
			o_blink_upper    <= 1'b0;
			hold_fired       <= 1'b0;
		end else begin
			o_disp_state     <= next_disp;
			o_disp_table_idx <= next_idx;
			o_blink_lower    <= (next_disp == `TCSI_DISP_SEL_TABLE);
			o_blink_upper    <= (next_disp == `TCSI_DISP_TEACH_RDY);
			if (timing_hold && timer_done) begin
				hold_fired <= 1'b1;
			end else if (set_fall) begin
				hold_fired <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Point table position storage
	// The table has no reset; an entry reads unknown until it is taught.
	reg [POS_W-1:0] table_mem [0:TABLE_DEPTH-1];
	wire            do_write;

	// Teach input acts only in the live, teach initial and teach-ready display states.
	assign do_write = teach_request && teach_allowed
			&& (o_disp_state == `TCSI_DISP_TEACH_RDY
			|| o_disp_state == `TCSI_DISP_TEACH_INIT
			|| o_disp_state == `TCSI_DISP_LIVE);

	always @(posedge i_clk) begin
		if (do_write) begin
			table_mem[o_disp_table_idx] <= i_cmd_position;
		end
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_table_rd_data <= {POS_W{1'b0}};
			o_teach_written <= 1'b0;
		end else begin
			o_table_rd_data <= table_mem[i_table_rd_idx];
			o_teach_written <= do_write;
		end
	end

	// ==========================================================
	// Speed warning
	wire over_limit;

	tcsi_speed_check #(
		.SPD_W  (SPD_W),
		.GEAR_W (GEAR_W)
	) u_speed (
		.i_clk            (i_clk),
		.i_nrst           (i_nrst),
		.i_speed_abs      (i_speed_abs),
		.i_gear_numerator (i_gear_numerator),
		.o_over_limit     (over_limit)
	);

	// ==========================================================
	// Stop reactions and start interlocks
	// The controller keeps starts and servo-on low around power changes, so
	// no extra power-up guard is needed here.
	reg        test_stop_latched;
	reg [2:0]  next_stop;
	wire       servo_on_state;
	wire       start_ok;
	wire       brake_alarm;

	// Brake-class alarms also cut the power stage so the brake can act.
	assign brake_alarm    = i_alarm && i_alarm_dbrake_class;
	assign servo_on_state = i_servo_on_input && i_forced_stop_two;
	assign start_ok = servo_on_state && !i_alarm
			&& !(i_test_mode && test_stop_latched)
			&& !i_operation_mode_select;

	always @* begin
		next_stop = `TCSI_STOP_NONE;
		if (!i_servo_on_input) begin
			next_stop = `TCSI_STOP_COAST;
		end else if (i_alarm) begin
			next_stop = i_alarm_dbrake_class ? `TCSI_STOP_DBRAKE :
					`TCSI_STOP_DECEL;
		end else if (i_test_mode && test_stop_latched) begin
			next_stop = `TCSI_STOP_INSTANT;
		end else if (!i_forced_stop_two) begin
			next_stop = `TCSI_STOP_DECEL;
		end else if (!i_fwd_stroke_limit || !i_rev_stroke_limit) begin
			next_stop = `TCSI_STOP_LOCK;
		end
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			test_stop_latched           <= 1'b0;
			o_drive_ready               <= 1'b0;
			o_power_stage_on            <= 1'b0;
			// Reset reads as coast: the power stage is off until servo-on.
			o_stop_action               <= `TCSI_STOP_COAST;
			o_run_fwd                   <= 1'b0;
			o_run_rev                   <= 1'b0;
			o_forced_stop_warning       <= 1'b0;
			o_abs_counter_speed_warning <= 1'b0;
		end else begin
			if (!i_test_mode) begin
				test_stop_latched <= 1'b0;
			end else if (tfs_rise) begin
				test_stop_latched <= ~test_stop_latched;
			end
			o_drive_ready    <= servo_on_state;
			o_power_stage_on <= i_servo_on_input
					&& !brake_alarm;
			o_stop_action    <= next_stop;
			// A blocked limit stops only its own direction.
			o_run_fwd <= start_ok && i_fwd_start_input
					&& i_fwd_stroke_limit;
			o_run_rev <= start_ok && i_rev_start_input
					&& i_rev_stroke_limit;
			o_forced_stop_warning <= i_servo_on_input
					&& !i_forced_stop_two;
			o_abs_counter_speed_warning <= over_limit;
		end
	end

endmodule

// ===== rtl/tcsi_defs.vh
// Constants for the teach capture and stop interlock block.
//
// Contract
// - Teach input or set button after motion ends stores commanded position.
// - Teach works only in point-table mode; otherwise nothing changes.
// - Teach allowed only when command method field equals 0 (absolute).
// - Teach allowed only while home return done is asserted.
// - Teach allowed only at rest: command output zero and travel complete.
// - Holding set about 2 s enters teach setting mode, lower digits blink.
// - Up/down step table number; set then makes upper digits blink.
// - Mode press while blinking returns to teach initial screen, no write.
// - Warn when speed exceeds 3076.7 r/min, or 3276.7*numerator/10 over 2000.
// - After power-on show startup indication, live data 2 s later.
// - Servo-on low shuts off power stage at once; motor coasts.
// - Alarm decelerates motor to stop; some alarm classes use dynamic brake.
// - Forced-stop-2 low decelerates along profile and raises stop warning.
// - Stroke limit low stops at once in servo lock; opposite way allowed.
// - Drive-ready asserted whenever in servo-on state.
// - Mode-select low means manual; a start input then starts rotation.
// - Test-mode forced stop halts at once and blocks starts until released.
`ifndef TCSI_DEFS_VH
`define TCSI_DEFS_VH

// ==========================================================
// Timing
`define TCSI_CLK_PERIOD_NS   10
`define TCSI_HOLD_TIME_MS    2000
`define TCSI_HOLD_CYCLES     (`TCSI_HOLD_TIME_MS*1000000/`TCSI_CLK_PERIOD_NS)

// ==========================================================
// Configuration values
`define TCSI_CMD_ABSOLUTE    4'h0
`define TCSI_GEAR_KNEE       32'd2000
// Speeds are in units of 0.1 r/min.
`define TCSI_SPEED_LOW_LIM   32'd30767
`define TCSI_SPEED_HIGH_K    32'd32767
`define TCSI_SPEED_HIGH_DIV  32'd10

// ==========================================================
// Display states
`define TCSI_DISP_STARTUP    3'h0
`define TCSI_DISP_LIVE       3'h1
`define TCSI_DISP_TEACH_INIT 3'h2
`define TCSI_DISP_SEL_TABLE  3'h3
`define TCSI_DISP_TEACH_RDY  3'h4

// ==========================================================
// Stop actions
`define TCSI_STOP_NONE       3'h0
`define TCSI_STOP_COAST      3'h1
`define TCSI_STOP_DECEL      3'h2
`define TCSI_STOP_DBRAKE     3'h3
`define TCSI_STOP_LOCK       3'h4
`define TCSI_STOP_INSTANT    3'h5

`endif

// ===== rtl/tcsi_speed_check.v
// Speed limit check for the absolute position counter warning.
`timescale 1ns/1ps
`include "tcsi_defs.vh"

module tcsi_speed_check #(
	parameter SPD_W  = 20,
	parameter GEAR_W = 24
) (
	// Clock and reset
	input  wire              i_clk,
	input  wire              i_nrst,
	// Measurements
	input  wire [SPD_W-1:0]  i_speed_abs,
	input  wire [GEAR_W-1:0] i_gear_numerator,
	// Result
	output reg               o_over_limit
);

	// ==========================================================
	// Limit computation
	// Compare speed*10 against 32767*gear to avoid a divider in the path.
	wire [63:0] lhs_high;
	wire [63:0] rhs_high;
	wire        high_gear;
	wire        next_over;

	assign lhs_high  = {{(64-SPD_W){1'b0}}, i_speed_abs} * 64'd10;
	assign rhs_high  = {{(64-GEAR_W){1'b0}}, i_gear_numerator}
			* {32'h0, `TCSI_SPEED_HIGH_K};
	assign high_gear = {{(32-GEAR_W){1'b0}}, i_gear_numerator}
			> `TCSI_GEAR_KNEE;
	assign next_over = high_gear ? (lhs_high > rhs_high) :
			({{(32-SPD_W){1'b0}}, i_speed_abs} > `TCSI_SPEED_LOW_LIM);

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_over_limit <= 1'b0;
		end else begin
			o_over_limit <= next_over;
		end
	end

endmodule

// ===== test/tcsi_checker.sv
// Property checker for the teach capture and stop interlock block.
`timescale 1ns/1ps
module tcsi_checker (
	input logic       i_clk,
	input logic       i_nrst,
	input logic       i_servo_on_input,
	input logic       i_forced_stop_two,
	input logic       i_fwd_stroke_limit,
	input logic       i_teach_input,
	input logic       i_point_table_mode,
	input logic [3:0] i_position_command_config,
	input logic       i_home_return_done,
	input logic       i_travel_complete,
	input logic       i_cmd_output_zero,
	input logic       i_alarm,
	input logic       i_alarm_dbrake_class,
	input logic       o_drive_ready,
	input logic       o_power_stage_on,
	input logic       o_run_fwd,
	input logic       o_forced_stop_warning,
	input logic [2:0] o_disp_state,
	input logic       o_teach_written
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// ==========================================================
	// Teach gating
	// The display gate keeps a teach from landing at startup or while the table number is being selected.
	logic teach_ok;
	assign teach_ok = i_point_table_mode && i_position_command_config == 4'h0
		&& i_home_return_done && i_cmd_output_zero && i_travel_complete
		&& (o_disp_state == 3'h1 || o_disp_state == 3'h2
		|| o_disp_state == 3'h4);
	a_teach_pulse: assert property (
		$rose(i_teach_input) && teach_ok |=> o_teach_written ##1
		!o_teach_written) else $error("teach did not write once");
	a_mode_blocks: assert property (
		!i_point_table_mode |=> !o_teach_written)
		else $error("write outside table mode");
	a_cfg_blocks: assert property (
		i_position_command_config != 4'h0 |=> !o_teach_written)
		else $error("write with relative commanding");
	a_home_blocks: assert property (
		!i_home_return_done |=> !o_teach_written)
		else $error("write before home return");
	a_motion_blocks: assert property (
		!(i_cmd_output_zero && i_travel_complete) |=> !o_teach_written)
		else $error("write while moving");
	// ==========================================================
	// Stop reactions
	a_servo_cut: assert property (
		!i_servo_on_input |=> !o_power_stage_on)
		else $error("power stage on without servo");
	a_dbrake_cut: assert property (
		i_alarm && i_alarm_dbrake_class |=> !o_power_stage_on)
		else $error("power stage on during brake alarm");
	a_stop_warn: assert property (
		i_servo_on_input && !i_forced_stop_two |=> o_forced_stop_warning)
		else $error("forced stop warning missing");
	a_limit_fwd: assert property (
		!i_fwd_stroke_limit |=> !o_run_fwd)
		else $error("forward run past limit");
	a_ready_follow: assert property (
		o_drive_ready == $past(i_servo_on_input && i_forced_stop_two))
		else $error("ready does not follow servo state");
	c_teach: cover property (o_teach_written);
	c_warn: cover property (o_forced_stop_warning);
	c_run: cover property (o_run_fwd);
endmodule

bind tcsi_top tcsi_checker u_tcsi_checker (.*);

// ===== test/tcsi_ctrl_model.sv
// Controller model driving servo-on and the two start inputs.
`timescale 1ns/1ps
module tcsi_ctrl_model (
	// Clock and reset
	input  wire i_clk,
	input  wire i_nrst,
	// Requests from the bench
	input  wire i_power,
	input  wire i_want_servo,
	input  wire i_want_fwd,
	input  wire i_want_rev,
	// Discrete lines to the drive
	output reg  o_servo_on,
	output reg  o_fwd_start,
	output reg  o_rev_start
);
	// ==========================================================
	// Sequencing
	// Servo-on lingers until both starts are down, so a power-down request
	// always drops the starts a cycle ahead of servo-on.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_servo_on  <= 1'b0;
			o_fwd_start <= 1'b0;
			o_rev_start <= 1'b0;
		end else begin
			o_fwd_start <= i_power && i_want_fwd && o_servo_on;
			o_rev_start <= i_power && i_want_rev && o_servo_on;
			o_servo_on  <= (i_power && i_want_servo) || (o_servo_on
				&& (o_fwd_start || o_rev_start));
		end
	end
endmodule

// ===== test/tb_tcsi_top.sv
// Self-checking bench for the teach capture and stop interlock block.
`timescale 1ns/1ps
`include "tcsi_defs.vh"
module tb_tcsi_top;
	reg         i_clk = 0, i_nrst = 0, pwr = 0, wso = 0, wf = 0, wr = 0;
	reg         fs2 = 0, lf = 1, lr = 1, md = 1, teach_input = 0, bs = 0, bm = 0;
	reg         bu = 0, bd = 0, ptm = 1, tm = 0, ts = 0, hm = 1, travel_complete = 1;
	reg         cz = 1, alm = 0, acl = 0;
	reg  [3:0]  cfg = 0;
	reg  [31:0] pos = 0;
	reg  [19:0] spd = 0;
	reg  [23:0] gr = 1;
	reg  [4:0]  ridx = 0;
	wire        servo_on_input, sf, sr, rdy, pst, rf, rrv, fsw, asw, bl, bup, tw;
	wire [31:0] rdat;
	wire [2:0]  sact, dst;
	wire [4:0]  didx;
	integer     n_fail = 0, checks_done = 0, k;
	tcsi_ctrl_model u_tcsi_ctrl_model (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_power(pwr), .i_want_servo(wso), .i_want_fwd(wf),
		.i_want_rev(wr), .o_servo_on(servo_on_input), .o_fwd_start(sf),
		.o_rev_start(sr));
	tcsi_top #(.HOLD_CYCLES(20)) u_tcsi_top (.i_clk(i_clk),
		.i_nrst(i_nrst), .i_servo_on_input(servo_on_input), .i_forced_stop_two(fs2),
		.i_fwd_stroke_limit(lf), .i_rev_stroke_limit(lr),
		.i_fwd_start_input(sf), .i_rev_start_input(sr),
		.i_operation_mode_select(md), .i_teach_input(teach_input), .i_btn_set(bs),
		.i_btn_mode(bm), .i_btn_up(bu), .i_btn_down(bd),
		.i_point_table_mode(ptm), .i_test_mode(tm), .i_test_forced_stop(ts),
		.i_position_command_config(cfg), .i_home_return_done(hm),
		.i_travel_complete(travel_complete), .i_cmd_output_zero(cz),
		.i_cmd_position(pos), .i_alarm(alm), .i_alarm_dbrake_class(acl),
		.i_speed_abs(spd), .i_gear_numerator(gr), .i_table_rd_idx(ridx),
		.o_table_rd_data(rdat), .o_drive_ready(rdy),
		.o_power_stage_on(pst), .o_stop_action(sact), .o_run_fwd(rf),
		.o_run_rev(rrv), .o_forced_stop_warning(fsw),
		.o_abs_counter_speed_warning(asw), .o_disp_state(dst),
		.o_disp_table_idx(didx), .o_blink_lower(bl), .o_blink_upper(bup),
		.o_teach_written(tw));
	// ==========================================================
	// Tasks
	always #5 i_clk = ~i_clk;
	task cyc(input integer n); begin
		repeat (n) @(posedge i_clk);
		#1;
	end endtask
	task chk(input [31:0] seen, input [31:0] exp); begin
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end endtask
	// Buttons need a low cycle between presses, hence the release edge.
	task press(input integer b); begin
		@(posedge i_clk);
		case (b)
			0: bs <= 1;
			1: bm <= 1;
			2: bu <= 1;
			default: bd <= 1;
		endcase
		@(posedge i_clk) {bs, bm, bu, bd} <= 4'h0;
		cyc(2);
	end endtask
	task teach(input exp_wr); begin
		@(posedge i_clk) teach_input <= 1;
		@(posedge i_clk) teach_input <= 0;
		#1;
		chk(tw, exp_wr);
		cyc(1);
		chk(tw, 0);
		cyc(2);
	end endtask
	task rd(input [4:0] i, input [31:0] exp); begin
		@(posedge i_clk) ridx <= i;
		cyc(2);
		chk(rdat, exp);
	end endtask
	task close_out; begin
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end endtask
	initial begin
		#60000;
		n_fail = n_fail + 1;
		close_out;
	end
	// ==========================================================
	// Tests
	initial begin
		cyc(2);
		chk(dst, `TCSI_DISP_STARTUP);
		@(posedge i_clk) begin i_nrst <= 1; pwr <= 1; end
		cyc(19);
		chk(dst, `TCSI_DISP_STARTUP);
		cyc(1);
		chk(dst, `TCSI_DISP_LIVE);
		@(posedge i_clk) begin wso <= 1; fs2 <= 1; md <= 0; end
		cyc(5);
		chk(rdy, 1);
		@(posedge i_clk) wf <= 1;
		cyc(4);
		chk(rf, 1);
		@(posedge i_clk) lf <= 0;
		cyc(2);
		chk(rf, 0);
		chk(sact, `TCSI_STOP_LOCK);
		@(posedge i_clk) begin wf <= 0; wr <= 1; end
		cyc(4);
		chk(rrv, 1);
		@(posedge i_clk) begin wr <= 0; lf <= 1; fs2 <= 0; end
		cyc(2);
		chk(sact, `TCSI_STOP_DECEL);
		chk(fsw, 1);
		chk(rdy, 0);
		@(posedge i_clk) fs2 <= 1;
		for (k = 0; k < 2; k = k + 1) begin
			@(posedge i_clk) begin alm <= 1; acl <= k[0]; end
			cyc(2);
			chk(sact, k ? `TCSI_STOP_DBRAKE : `TCSI_STOP_DECEL);
			chk(pst, !k);
		end
		@(posedge i_clk) begin alm <= 0; tm <= 1; ts <= 1; wf <= 1; end
		@(posedge i_clk) ts <= 0;
		cyc(4);
		chk(rf, 0);
		chk(sact, `TCSI_STOP_INSTANT);
		@(posedge i_clk) ts <= 1;
		@(posedge i_clk) ts <= 0;
		cyc(4);
		chk(rf, 1);
		@(posedge i_clk) begin tm <= 0; wf <= 0; pos <= 32'h1234abcd; end
		teach(1);
		rd(0, 32'h1234abcd);
		for (k = 0; k < 5; k = k + 1) begin
			@(posedge i_clk) begin
				pos <= k + 1;
				cfg <= {3'h0, k == 0};
				hm <= (k != 1);
				travel_complete <= (k != 2);
				cz <= (k != 3);
				ptm <= (k != 4);
			end
			teach(0);
			rd(0, 32'h1234abcd);
			chk(dst, `TCSI_DISP_LIVE);
		end
		@(posedge i_clk) begin cfg <= 0; ptm <= 1; pos <= 32'h0badcafe; end
		press(1);
		chk(dst, `TCSI_DISP_TEACH_INIT);
		@(posedge i_clk) bs <= 1;
		cyc(20);
		chk(bl, 0);
		cyc(5);
		chk(bl, 1);
		@(posedge i_clk) bs <= 0;
		press(2);
		chk(didx, 1);
		press(3);
		press(3);
		chk(didx, 31);
		press(0);
		chk(bup, 1);
		chk(bl, 0);
		press(0);
		rd(31, 32'h0badcafe);
		press(1);
		chk(dst, `TCSI_DISP_TEACH_INIT);
		chk(bup, 0);
		@(posedge i_clk) begin bs <= 1; pos <= 32'h55; end
		cyc(25);
		@(posedge i_clk) bs <= 0;
		press(1);
		chk(dst, `TCSI_DISP_TEACH_INIT);
		rd(31, 32'h0badcafe);
		for (k = 0; k < 3; k = k + 1) begin
			@(posedge i_clk) begin
				gr <= (k == 2) ? 24'd2001 : 24'd2000;
				spd <= (k == 2) ? 20'hfffff : 20'd30767 + k;
			end
			cyc(4);
			chk(asw, k == 1);
		end
		@(posedge i_clk) wso <= 0;
		cyc(3);
		chk(pst, 0);
		chk(sact, `TCSI_STOP_COAST);
		close_out;
	end
endmodule
